// >>> core/htc_pkg.sv
package htc_pkg;

    // ----------------------------------------------------------------
    // Operand format and channel count.
    // ----------------------------------------------------------------
    localparam int unsigned HTC_DATA_W = 16;
    localparam int unsigned HTC_NUM_CH = 8;
    localparam int unsigned HTC_ADDR_W = 8;
    localparam int unsigned HTC_SRC_W  = 2;
    localparam int unsigned HTC_CHS_W  = 3;
    localparam int unsigned HTC_FLD_W  = HTC_SRC_W + HTC_CHS_W;

    // ----------------------------------------------------------------
    // Register byte offsets.
    // ----------------------------------------------------------------
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_CFG      = 8'h00;
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_CONST_IN = 8'h04;
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_CONST_LO = 8'h08;
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_CONST_HI = 8'h0C;
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_STATUS   = 8'h10;
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_CAP_IN   = 8'h14;
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_CAP_LO   = 8'h18;
    localparam logic [HTC_ADDR_W-1:0] HTC_OFF_CAP_HI   = 8'h1C;

    // ----------------------------------------------------------------
    // Field positions, masks and reset values.
    // ----------------------------------------------------------------
    localparam int unsigned HTC_CFG_IN_LSB = 0;
    localparam int unsigned HTC_CFG_LO_LSB = 8;
    localparam int unsigned HTC_CFG_HI_LSB = 16;
    localparam int unsigned HTC_ST_OUT     = 0;
    localparam int unsigned HTC_ST_INV     = 1;
    localparam int unsigned HTC_ST_EN      = 2;
    localparam logic [31:0] HTC_CFG_MASK   = 32'h001F_1F1F;
    localparam logic [31:0] HTC_CFG_RST    = 32'h0000_0000;
    localparam logic [HTC_DATA_W-1:0] HTC_CONST_RST = 16'h0000;
    localparam logic [HTC_CHS_W-1:0]  HTC_CH_FIRST  = 3'h0;

    // Operand source selection.
    typedef enum logic [HTC_SRC_W-1:0] {
        HTC_SRC_CONST,
        HTC_SRC_ANALOG,
        HTC_SRC_BLOCK,
        HTC_SRC_SPARE
    } htc_src_t;

    // Bus slave states.
    typedef enum logic {
        HTC_APB_IDLE,
        HTC_APB_RESP
    } htc_apb_st_t;

    // Widens an operand to a bus word with the upper bits at zero.
    function automatic logic [31:0] htc_word(input logic [HTC_DATA_W-1:0] v);
        return {16'h0000, v};
    endfunction

    // Picks the operand's source field out of the configuration word.
    function automatic htc_src_t htc_src_of(input logic [31:0] cfg, input int unsigned lsb);
        return htc_src_t'(cfg[lsb +: HTC_SRC_W]);
    endfunction

    // Picks the operand's channel field out of the configuration word.
    function automatic logic [HTC_CHS_W-1:0] htc_ch_of(input logic [31:0] cfg,
                                                       input int unsigned lsb);
        return cfg[lsb + HTC_SRC_W +: HTC_CHS_W];
    endfunction

endpackage

// >>> core/htc_operand_sel.sv
`timescale 1ns/1ps
module htc_operand_sel
    import htc_pkg::*;
#(
    parameter int unsigned N_CH = HTC_NUM_CH
) (
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic                         enable,
    input  wire htc_src_t                     src,
    input  wire logic [HTC_CHS_W-1:0]         chan,
    input  wire logic signed [HTC_DATA_W-1:0] const_val,
    input  wire logic [N_CH*HTC_DATA_W-1:0]   analog_ch,
    input  wire logic signed [HTC_DATA_W-1:0] block_val,
    output logic signed [HTC_DATA_W-1:0]      live_val,
    output logic signed [HTC_DATA_W-1:0]      held_q
);

    logic signed [HTC_DATA_W-1:0] held_d;

    // Routes the chosen source; an out-of-range channel falls back to the first.
    always_comb begin
        live_val = const_val;
        case (src)
            HTC_SRC_ANALOG: begin
                if (32'(chan) < N_CH) begin
                    live_val = $signed(analog_ch[32'(chan)*HTC_DATA_W +: HTC_DATA_W]);
                end else begin
                    live_val = $signed(analog_ch[0 +: HTC_DATA_W]);
                end
            end
            HTC_SRC_BLOCK: live_val = block_val;
            default:       live_val = const_val;
        endcase
    end

    always_comb begin
        held_d = held_q;
        if (enable) begin
            held_d = live_val;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            held_q <= HTC_CONST_RST;
        end else begin
            held_q <= held_d;
        end
    end

    a_held_when_off: assert property (
        @(posedge sys_clk) disable iff (rst)
        !enable |=> $stable(held_q))
        else $error("Captured operand changed while enable was low.");

    a_sample_when_on: assert property (
        @(posedge sys_clk) disable iff (rst)
        enable |=> held_q == $past(live_val))
        else $error("Captured operand missed the sampled value.");

endmodule

// >>> core/htc_hyst_core.sv
`timescale 1ns/1ps
module htc_hyst_core
    import htc_pkg::*;
(
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic                         enable,
    input  wire logic signed [HTC_DATA_W-1:0] in_val,
    input  wire logic signed [HTC_DATA_W-1:0] lo_val,
    input  wire logic signed [HTC_DATA_W-1:0] hi_val,
    output logic                              out_q,
    output logic                              inv_q
);

    logic out_d;
    logic inv_d;
    logic inv_now;

    assign inv_now = hi_val < lo_val;

    // Decides the next output level from the live operands.
    always_comb begin
        out_d = out_q;
        inv_d = inv_q;
        if (enable) begin
            inv_d = inv_now;
            if (!inv_now) begin
                if (in_val >= hi_val) begin
                    out_d = 1'b1;
                end else if (in_val <= lo_val) begin
                    out_d = 1'b0;
                end
            end else begin
                if (in_val >= lo_val) begin
                    out_d = 1'b0;
                end else if (in_val <= hi_val) begin
                    out_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            out_q <= 1'b0;
            inv_q <= 1'b0;
        end else begin
            out_q <= out_d;
            inv_q <= inv_d;
        end
    end

    a_set_at_high: assert property (
        @(posedge sys_clk) disable iff (rst)
        (enable && hi_val > lo_val && in_val >= hi_val) |=> out_q)
        else $error("Output not set at or above the high limit.");

    a_clear_at_low: assert property (
        @(posedge sys_clk) disable iff (rst)
        (enable && hi_val > lo_val && in_val <= lo_val) |=> !out_q)
        else $error("Output not cleared at or below the low limit.");

    a_band_holds: assert property (
        @(posedge sys_clk) disable iff (rst)
        (enable && in_val > lo_val && in_val < hi_val) |=> out_q == $past(out_q))
        else $error("Output changed while the input was inside the band.");

    a_inv_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        (enable && hi_val < lo_val && in_val >= lo_val) |=> !out_q)
        else $error("Inverted ordering did not clear the output.");

    a_inv_set: assert property (
        @(posedge sys_clk) disable iff (rst)
        (enable && hi_val < lo_val && in_val <= hi_val) |=> out_q)
        else $error("Inverted ordering did not set the output.");

endmodule

// >>> core/htc_threshold_toggle_block.sv
`timescale 1ns/1ps
// Overview of operation
// - Every operand is a signed 16-bit value and a constant operand resets to zero.
// - Each operand takes a stored constant, analog channel one to eight, or another block's value.
// - In normal ordering the output goes active once the input reaches the high limit.
// - In normal ordering the output goes inactive once the input falls to the low limit.
// - In normal ordering an input between the limits leaves the output unchanged.
// - In inverted ordering an input at or above the low limit makes the output inactive.
// - In inverted ordering an input at or below the high limit makes the output active.
// - Channel and block operands are captured only while enable is high, else held.
// - Comparison and output change happen only in cycles with enable high.
// - Dropping enable never forces the output off; it simply holds.
module htc_threshold_toggle_block
    import htc_pkg::*;
#(
    parameter int unsigned N_CH = HTC_NUM_CH
) (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [HTC_ADDR_W-1:0]      paddr,
    input  wire logic [31:0]                pwdata,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       cmp_enable,
    input  wire logic [N_CH*HTC_DATA_W-1:0] analog_ch,
    input  wire logic [HTC_DATA_W-1:0]      blk_in_operand,
    input  wire logic [HTC_DATA_W-1:0]      blk_lo_operand,
    input  wire logic [HTC_DATA_W-1:0]      blk_hi_operand,
    output logic                            toggle_out
);

    // ----------------------------------------------------------------
    // Parameter check.
    // ----------------------------------------------------------------
    if (N_CH < 1 || N_CH > (1 << HTC_CHS_W)) begin : g_bad_ch
        $error("N_CH must lie between one and the channel field's reach.");
    end

    // ----------------------------------------------------------------
    // Declarations.
    // ----------------------------------------------------------------
    htc_apb_st_t                  st_q;
    htc_apb_st_t                  st_d;
    logic [31:0]                  cfg_q;
    logic [31:0]                  cfg_d;
    logic [HTC_DATA_W-1:0]        cin_q;
    logic [HTC_DATA_W-1:0]        cin_d;
    logic [HTC_DATA_W-1:0]        clo_q;
    logic [HTC_DATA_W-1:0]        clo_d;
    logic [HTC_DATA_W-1:0]        chi_q;
    logic [HTC_DATA_W-1:0]        chi_d;
    logic [31:0]                  prdata_q;
    logic [31:0]                  prdata_d;
    logic                         pready_q;
    logic                         pready_d;
    logic                         pslverr_q;
    logic                         pslverr_d;
    logic [31:0]                  rd_word;
    logic                         addr_hit;
    logic                         wr_commit;
    logic signed [HTC_DATA_W-1:0] live_in;
    logic signed [HTC_DATA_W-1:0] live_lo;
    logic signed [HTC_DATA_W-1:0] live_hi;
    logic signed [HTC_DATA_W-1:0] cap_in;
    logic signed [HTC_DATA_W-1:0] cap_lo;
    logic signed [HTC_DATA_W-1:0] cap_hi;
    logic                         out_level;
    logic                         inv_level;

    // ----------------------------------------------------------------
    // Operand paths.
    // ----------------------------------------------------------------

    htc_operand_sel #(
        .N_CH (N_CH)
    ) u_op_in (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (cmp_enable),
        .src       (htc_src_of(cfg_q, HTC_CFG_IN_LSB)),
        .chan      (htc_ch_of(cfg_q, HTC_CFG_IN_LSB)),
        .const_val ($signed(cin_q)),
        .analog_ch (analog_ch),
        .block_val ($signed(blk_in_operand)),
        .live_val  (live_in),
        .held_q    (cap_in)
    );

    htc_operand_sel #(
        .N_CH (N_CH)
    ) u_op_lo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (cmp_enable),
        .src       (htc_src_of(cfg_q, HTC_CFG_LO_LSB)),
        .chan      (htc_ch_of(cfg_q, HTC_CFG_LO_LSB)),
        .const_val ($signed(clo_q)),
        .analog_ch (analog_ch),
        .block_val ($signed(blk_lo_operand)),
        .live_val  (live_lo),
        .held_q    (cap_lo)
    );

    htc_operand_sel #(
        .N_CH (N_CH)
    ) u_op_hi (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (cmp_enable),
        .src       (htc_src_of(cfg_q, HTC_CFG_HI_LSB)),
        .chan      (htc_ch_of(cfg_q, HTC_CFG_HI_LSB)),
        .const_val ($signed(chi_q)),
        .analog_ch (analog_ch),
        .block_val ($signed(blk_hi_operand)),
        .live_val  (live_hi),
        .held_q    (cap_hi)
    );

    htc_hyst_core u_core (
        .sys_clk (sys_clk),
        .rst     (rst),
        .enable  (cmp_enable),
        .in_val  (live_in),
        .lo_val  (live_lo),
        .hi_val  (live_hi),
        .out_q   (out_level),
        .inv_q   (inv_level)
    );

    assign toggle_out = out_level; // Straight from the core's output flop.

    // ----------------------------------------------------------------
    // Register read decode.
    // ----------------------------------------------------------------

    // Selects the read word and flags addresses outside the map.
    always_comb begin
        rd_word  = 32'h0000_0000;
        addr_hit = 1'b1;
        case (paddr)
            HTC_OFF_CFG:      rd_word = cfg_q;
            HTC_OFF_CONST_IN: rd_word = htc_word(cin_q);
            HTC_OFF_CONST_LO: rd_word = htc_word(clo_q);
            HTC_OFF_CONST_HI: rd_word = htc_word(chi_q);
            HTC_OFF_STATUS: begin
                rd_word[HTC_ST_OUT] = out_level;
                rd_word[HTC_ST_INV] = inv_level;
                rd_word[HTC_ST_EN]  = cmp_enable;
            end
            HTC_OFF_CAP_IN:   rd_word = htc_word(cap_in);
            HTC_OFF_CAP_LO:   rd_word = htc_word(cap_lo);
            HTC_OFF_CAP_HI:   rd_word = htc_word(cap_hi);
            default:          addr_hit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Bus slave sequence and register writes.
    // ----------------------------------------------------------------

    assign wr_commit = (st_q == HTC_APB_RESP) && psel && penable && pwrite && addr_hit;

    // Answers every access after its setup cycle and stores writes at completion.
    always_comb begin
        st_d      = st_q;
        prdata_d  = 32'h0000_0000;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        cfg_d     = cfg_q;
        cin_d     = cin_q;
        clo_d     = clo_q;
        chi_d     = chi_q;
        case (st_q)
            HTC_APB_IDLE: begin
                if (psel && !penable) begin
                    st_d      = HTC_APB_RESP;
                    pready_d  = 1'b1;
                    pslverr_d = !addr_hit;
                    prdata_d  = pwrite ? 32'h0000_0000 : rd_word;
                end
            end
            HTC_APB_RESP: begin
                st_d = HTC_APB_IDLE;
                if (wr_commit) begin
                    case (paddr)
                        HTC_OFF_CFG:      cfg_d = pwdata & HTC_CFG_MASK;
                        HTC_OFF_CONST_IN: cin_d = pwdata[HTC_DATA_W-1:0];
                        HTC_OFF_CONST_LO: clo_d = pwdata[HTC_DATA_W-1:0];
                        HTC_OFF_CONST_HI: chi_d = pwdata[HTC_DATA_W-1:0];
                        default:          cfg_d = cfg_q;
                    endcase
                end
            end
            default: st_d = HTC_APB_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q      <= HTC_APB_IDLE;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            cfg_q     <= HTC_CFG_RST;
            cin_q     <= HTC_CONST_RST;
            clo_q     <= HTC_CONST_RST;
            chi_q     <= HTC_CONST_RST;
        end else begin
            st_q      <= st_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            cfg_q     <= cfg_d;
            cin_q     <= cin_d;
            clo_q     <= clo_d;
            chi_q     <= chi_d;
        end
    end

    assign prdata  = prdata_q;  // Registered read data.
    assign pready  = pready_q;  // Registered ready.
    assign pslverr = pslverr_q; // Registered error.

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------

    a_reset_clears: assert property (
        @(posedge sys_clk)
        rst |=> (!toggle_out && cap_in == 0 && cap_lo == 0 && cap_hi == 0))
        else $error("Reset left the output or a captured operand set.");

    a_const_reset: assert property (
        @(posedge sys_clk)
        rst |=> (cin_q == HTC_CONST_RST && clo_q == HTC_CONST_RST && cfg_q == HTC_CFG_RST))
        else $error("Constant operands did not return to zero.");

    a_hold_disabled: assert property (
        @(posedge sys_clk) disable iff (rst)
        !cmp_enable |=> toggle_out == $past(toggle_out))
        else $error("Output moved while enable was low.");

    a_no_compare_off: assert property (
        @(posedge sys_clk) disable iff (rst)
        (!cmp_enable [*2]) |-> $stable(toggle_out) && $stable(inv_level))
        else $error("Comparison state changed without enable.");

    a_analog_route: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cmp_enable && htc_src_of(cfg_q, HTC_CFG_IN_LSB) == HTC_SRC_ANALOG
            && 32'(htc_ch_of(cfg_q, HTC_CFG_IN_LSB)) < N_CH)
        |=> cap_in == $past($signed(
            analog_ch[32'(htc_ch_of(cfg_q, HTC_CFG_IN_LSB))*HTC_DATA_W +: HTC_DATA_W])))
        else $error("Selected analog channel was not captured as the input.");

    a_ready_single: assert property (
        @(posedge sys_clk) disable iff (rst)
        (psel && !penable && st_q == HTC_APB_IDLE) |=> pready ##1 !pready)
        else $error("Ready did not answer for exactly one cycle.");

    a_status_read: assert property (
        @(posedge sys_clk) disable iff (rst)
        (psel && !penable && !pwrite && paddr == HTC_OFF_STATUS && st_q == HTC_APB_IDLE)
        |=> prdata[HTC_ST_OUT] == $past(toggle_out))
        else $error("Status read did not show the output level.");

    a_cfg_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_commit && paddr == HTC_OFF_CFG |=> cfg_q == ($past(pwdata) & HTC_CFG_MASK))
        else $error("Source configuration write was not stored.");

    a_const_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_commit && paddr == HTC_OFF_CONST_IN |=> cin_q == $past(pwdata[HTC_DATA_W-1:0]))
        else $error("Constant input write was not stored.");

    a_const_route: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cmp_enable && htc_src_of(cfg_q, HTC_CFG_HI_LSB) == HTC_SRC_CONST)
        |=> cap_hi == $past($signed(chi_q)))
        else $error("Constant high limit was not captured.");

    a_block_route: assert property (
        @(posedge sys_clk) disable iff (rst)
        (cmp_enable && htc_src_of(cfg_q, HTC_CFG_LO_LSB) == HTC_SRC_BLOCK)
        |=> cap_lo == $past($signed(blk_lo_operand)))
        else $error("Block value was not captured as the low limit.");

    a_order_status: assert property (
        @(posedge sys_clk) disable iff (rst)
        cmp_enable |=> inv_level == ($past(live_hi) < $past(live_lo)))
        else $error("Ordering flag does not match the signed limits.");

endmodule

// >>> test/htc_far_model.sv
`timescale 1ns/1ps
module htc_far_model
    import htc_pkg::*;
(
    input  wire logic                        sys_clk,
    input  wire logic                        ld,
    input  wire logic [3:0]                  idx,
    input  wire logic [HTC_DATA_W-1:0]       val,
    output logic [HTC_NUM_CH*HTC_DATA_W-1:0] analog_ch,
    output logic [HTC_DATA_W-1:0]            blk_in,
    output logic [HTC_DATA_W-1:0]            blk_lo,
    output logic [HTC_DATA_W-1:0]            blk_hi
);
    // ------------------------------------------------------------
    // Eight analog channels, then block values for in, low, high.
    // ------------------------------------------------------------
    logic [HTC_DATA_W-1:0] src_q [0:10];

    // Each source starts at its own index so a wrong pick shows.
    initial begin
        for (int k = 0; k < 11; k++) begin
            src_q[k] = 16'(k);
        end
    end

    // A loaded source changes at the clock edge, like sampled logic.
    always @(posedge sys_clk) begin
        if (ld) begin
            src_q[idx] <= val;
        end
    end

    always_comb begin
        for (int k = 0; k < HTC_NUM_CH; k++) begin
            analog_ch[k*HTC_DATA_W +: HTC_DATA_W] = src_q[k];
        end
        blk_in = src_q[8];
        blk_lo = src_q[9];
        blk_hi = src_q[10];
    end
endmodule

// >>> test/htc_threshold_toggle_block_test.sv
`timescale 1ns/1ps
module htc_threshold_toggle_block_test import htc_pkg::*;;
    // ------------------------------------------------------------
    // Stimulus signals and counters.
    // ------------------------------------------------------------
    logic                            sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic                            pwrite = 1'b0, cmp_enable = 1'b0, ld = 1'b0;
    logic [7:0]                      paddr = 8'h00;
    logic [31:0]                     pwdata = 32'h0000_0000, prdata, bus_rd;
    logic                            pready, pslverr, toggle_out, bus_err;
    logic [3:0]                      idx = 4'h0;
    logic [15:0]                     val = 16'h0000, blk_in, blk_lo, blk_hi;
    logic [HTC_NUM_CH*HTC_DATA_W-1:0] analog_ch;
    int                              miscompares = 0, n_checks = 0;

    htc_threshold_toggle_block i_htc_threshold_toggle_block (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_enable(cmp_enable), .analog_ch(analog_ch),
        .blk_in_operand(blk_in), .blk_lo_operand(blk_lo), .blk_hi_operand(blk_hi),
        .toggle_out(toggle_out));
    htc_far_model i_htc_far_model (
        .sys_clk(sys_clk), .ld(ld), .idx(idx), .val(val), .analog_ch(analog_ch),
        .blk_in(blk_in), .blk_lo(blk_lo), .blk_hi(blk_hi));

    // The clock toggles every half period of 25 ns.
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared tasks.
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // One bus transfer, entered right after a rising edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1);
        chk("pready wait", 32'(n), 32'h0000_0001);
        bus_rd = prdata;
        bus_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, bus_rd, exp);
        chk("pslverr", 32'(bus_err), 32'(a > HTC_OFF_CAP_HI));
    endtask

    // One enabled cycle with a new constant input, then the output check.
    task automatic step(input logic [15:0] v, input logic exp);
        wr(HTC_OFF_CONST_IN, {16'h0000, v});
        cmp_enable <= 1'b1;
        @(posedge sys_clk);
        cmp_enable <= 1'b0;
        @(posedge sys_clk);
        chk("toggle_out", 32'(toggle_out), 32'(exp));
    endtask

    // Applies eight inputs, the leftmost first.
    task automatic run8(input logic [7:0][15:0] ins, input logic [7:0] ex);
        for (int k = 7; k >= 0; k--) begin
            step(ins[k], ex[k]);
        end
    endtask

    task automatic load(input logic [3:0] i, input logic [15:0] v);
        ld <= 1'b1;
        idx <= i;
        val <= v;
        @(posedge sys_clk);
        ld <= 1'b0;
        @(posedge sys_clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios.
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("toggle_out", 32'(toggle_out), 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            rd(8'(4 * k), 32'h0000_0000, "reset value");
        end
        $display("t_reset done");
    endtask

    task automatic t_bus();
        wr(HTC_OFF_CFG, 32'hFFFF_FFFF);
        rd(HTC_OFF_CFG, HTC_CFG_MASK, "cfg mask");
        wr(HTC_OFF_CFG, HTC_CFG_RST);
        wr(HTC_OFF_CAP_IN, 32'h0000_1234);
        rd(HTC_OFF_CAP_IN, 32'h0000_0000, "cap read only");
        rd(8'h20, 32'h0000_0000, "unmapped");
        $display("t_bus done");
    endtask

    task automatic t_normal();
        wr(HTC_OFF_CONST_LO, 32'h0000_FF9C);
        wr(HTC_OFF_CONST_HI, 32'h0000_00C8);
        run8({16'h00C8, 16'h0000, 16'hFF9D, 16'hFF9C, 16'h00C7, 16'h7FFF, 16'h8000,
              16'h7FFF}, 8'hE5);
        rd(HTC_OFF_STATUS, 32'h0000_0001, "status normal");
        $display("t_normal done");
    endtask

    task automatic t_inverted();
        wr(HTC_OFF_CONST_LO, 32'h0000_0032);
        wr(HTC_OFF_CONST_HI, 32'h0000_FFCE);
        run8({16'h0032, 16'h0000, 16'hFFCE, 16'h0000, 16'h8000, 16'h0031, 16'h0033,
              16'hFFCE}, 8'h3D);
        rd(HTC_OFF_STATUS, 32'h0000_0003, "status inverted");
        $display("t_inverted done");
    endtask

    task automatic t_enable();
        wr(HTC_OFF_CONST_IN, 32'h0000_7FFF);
        repeat (5) @(posedge sys_clk);
        chk("held output", 32'(toggle_out), 32'h0000_0001);
        rd(HTC_OFF_CAP_IN, 32'h0000_FFCE, "held capture");
        cmp_enable <= 1'b1;
        @(posedge sys_clk);
        rd(HTC_OFF_STATUS, 32'h0000_0006, "status enabled");
        cmp_enable <= 1'b0;
        chk("toggle_out", 32'(toggle_out), 32'h0000_0000);
        $display("t_enable done");
    endtask

    task automatic t_sources();
        wr(HTC_OFF_CFG, 32'h0009_021D);
        load(4'h7, 16'h0100);
        load(4'h2, 16'h0080);
        load(4'h9, 16'hFF00);
        step(16'h0000, 1'b1);
        rd(HTC_OFF_CAP_IN, 32'h0000_0100, "cap in");
        rd(HTC_OFF_CAP_LO, 32'h0000_FF00, "cap lo");
        rd(HTC_OFF_CAP_HI, 32'h0000_0080, "cap hi");
        load(4'h7, 16'hFF00);
        rd(HTC_OFF_CAP_IN, 32'h0000_0100, "cap in held");
        chk("held output", 32'(toggle_out), 32'h0000_0001);
        step(16'h0000, 1'b0);
        $display("t_sources done");
    endtask

    // Main sequence: reset for four cycles, then every scenario.
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        t_bus();
        t_normal();
        t_inverted();
        t_enable();
        t_sources();
        summarize();
    end

    // The run needs under a thousand cycles, so this cuts a hang short.
    initial begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        summarize();
    end
endmodule
